// ---- rtl/mbp_pkg.sv ----
// ==========================================
// package for the multiplexed bus pin block
package mbp_pkg;
    localparam int OFS_W = 6;
    localparam logic [5:0] OFS_A_DATA = 6'h00;
    localparam logic [5:0] OFS_B_DATA = 6'h01;
    localparam logic [5:0] OFS_A_DIR = 6'h02;
    localparam logic [5:0] OFS_B_DIR = 6'h03;
    localparam logic [5:0] OFS_RSVD_04 = 6'h04;
    localparam logic [5:0] OFS_E_DATA = 6'h08;
    localparam logic [5:0] OFS_E_DIR = 6'h09;
    localparam logic [5:0] OFS_ASSIGN = 6'h0A;
    localparam logic [5:0] OFS_MODE = 6'h0B;
    localparam logic [5:0] OFS_PULL = 6'h0C;
    localparam logic [5:0] OFS_DRIVE = 6'h0D;
    localparam logic [5:0] OFS_EBI = 6'h0E;
    localparam logic [5:0] OFS_IRQ = 6'h1E;
    localparam logic [5:0] OFS_K_DATA = 6'h32;
    localparam logic [5:0] OFS_K_DIR = 6'h33;
    // field positions
    localparam int ASG_STROBE_OFF = 4;
    localparam int ASG_LOW_BYTE_STROBE_N_EN = 3;
    localparam int ASG_RW_EN = 2;
    localparam int MODE_VIS = 3;
    localparam int EBI_STRETCH = 0;
    localparam int EBI_TAG = 4;
    localparam int IRQ_EDGE = 7;
    localparam int IRQ_EN = 6;
    localparam logic [7:0] E_INPUT_ONLY = 8'h03;
    localparam logic [7:0] E_PERI_IN = 8'h1C;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_IRQ = 8'h40;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int DATA_NS = 40;
    localparam int STRETCH_NS = 20;
    localparam logic [3:0] DATA_CYC = 4'((DATA_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] STRETCH_CYC =
        4'((STRETCH_NS * CLK_MHZ + 999) / 1000);
    typedef enum logic [2:0] {
        MD_SSC = 3'h0, MD_EMN = 3'h1, MD_STEST = 3'h2, MD_EMW = 3'h3,
        MD_NSC = 3'h4, MD_NXN = 3'h5, MD_PERI = 3'h6, MD_NXW = 3'h7
    } mbp_mode_e;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1, ST_ADDR = 3'h2, ST_DATA = 3'h4
    } mbp_state_e;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [5:0] page;
        logic write;
        logic wide;
        logic slow;
        logic internal;
    } mbp_req_s;
endpackage : mbp_pkg

// ---- rtl/mbp_top.sv ----
`timescale 1ns/1ns
// Contract
// - free-running strobe toggles every idle cycle
// - gated strobe: one low-high pulse per visible access
// - strobe set by disable, visibility, stretch bits
// - low byte strobe low when low lanes valid
// - low tag sampled at strobe falling edge
// - read/write pin output, input in peripheral mode
// - control pin 1 input-only, always readable
// - maskable interrupt level or edge sensitive
// - control pin registers at offsets 08 to 0B
// - decode only offset bits, base relocatable
// - mode straps captured at reset release
// - address while strobe low, data while high
module mbp_top
    import mbp_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire mbp_pkg::mbp_req_s req,
    input wire logic req_valid,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] a_in,
    output logic [7:0] a_out,
    output logic [7:0] a_oe,
    input wire logic [7:0] b_in,
    output logic [7:0] b_out,
    output logic [7:0] b_oe,
    input wire logic [7:0] e_in,
    output logic [7:0] e_out,
    output logic [7:0] e_oe,
    input wire logic [7:0] k_in,
    output logic [7:0] k_out,
    output logic [7:0] k_oe,
    input wire logic mode_strap_c,
    input wire logic irq_ack,
    output logic maskable_irq,
    output logic nonmaskable_interrupt_request,
    output logic low_tag_hit,
    output logic tester_write,
    output logic tester_byte,
    output logic [7:0] pull_enable,
    output logic [7:0] reduce_drive
);
    import mbp_pkg::*;

    // ==========================================
    // pin synchronisers
    logic [32:0] s1;
    logic [32:0] s2;
    logic [32:0] s3;
    logic [32:0] held, pin;
    logic [7:0] pa;
    logic [7:0] pb;
    logic [7:0] pe;
    logic [7:0] pk;

    always_ff @(posedge clk) begin
        s1 <= {mode_strap_c, k_in, e_in, b_in, a_in};
        s2 <= s1;
        s3 <= s2;
        held <= pin;
    end

    assign pin = (s2 & s3) | (held & (s2 ^ s3));

    assign pa = pin[7:0];
    assign pb = pin[15:8];
    assign pe = pin[23:16];
    assign pk = pin[31:24];

    // ==========================================
    // registers
    logic [OFS_W-1:0] ofs;
    logic [7:0] a_dat, b_dat, a_dir, b_dir;
    logic [7:0] e_dat, e_dir, asg, ebi, irqc, k_dat, k_dir;
    logic vis;
    logic rst_d;
    mbp_mode_e mode_f;
    logic [7:0] next_rdata;
    logic [7:0] e_rd;

    assign ofs = reg_addr[OFS_W-1:0];

    always_ff @(posedge clk) begin
        if (reset) begin
            a_dat <= RST_BYTE;
            b_dat <= RST_BYTE;
            a_dir <= RST_BYTE;
            b_dir <= RST_BYTE;
            e_dat <= RST_BYTE;
            e_dir <= RST_BYTE;
            asg <= RST_BYTE;
            vis <= 1'b0;
            pull_enable <= RST_BYTE;
            reduce_drive <= RST_BYTE;
            ebi <= RST_BYTE;
            irqc <= RST_IRQ;
            k_dat <= RST_BYTE;
            k_dir <= RST_BYTE;
        end else if (reg_write) begin
            case (ofs)
                OFS_A_DATA: a_dat <= reg_wdata;
                OFS_B_DATA: b_dat <= reg_wdata;
                OFS_A_DIR: a_dir <= reg_wdata;
                OFS_B_DIR: b_dir <= reg_wdata;
                OFS_E_DATA: e_dat <= reg_wdata;
                OFS_E_DIR: e_dir <= reg_wdata & ~E_INPUT_ONLY;
                OFS_ASSIGN: asg <= reg_wdata;
                OFS_MODE: vis <= reg_wdata[MODE_VIS];
                OFS_PULL: pull_enable <= reg_wdata;
                OFS_DRIVE: reduce_drive <= reg_wdata;
                OFS_EBI: ebi <= reg_wdata;
                OFS_IRQ: irqc <= reg_wdata;
                OFS_K_DATA: k_dat <= reg_wdata;
                OFS_K_DIR: k_dir <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        rst_d <= reset;
    end

    // mode: straps at release, software only in special modes
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_f <= MD_SSC;
        end else if (rst_d) begin
            mode_f <= mbp_mode_e'({pin[32], pe[6], pe[5]});
        end else if (reg_write && ofs == OFS_MODE && !mode_f[2]) begin
            mode_f <= mbp_mode_e'(reg_wdata[7:5]);
        end
    end

    assign e_rd = (e_dir & e_dat) | (~e_dir & pe);

    always_comb begin
        next_rdata = 8'h00;
        case (ofs)
            OFS_A_DATA: next_rdata = (a_dir & a_dat) | (~a_dir & pa);
            OFS_B_DATA: next_rdata = (b_dir & b_dat) | (~b_dir & pb);
            OFS_A_DIR: next_rdata = a_dir;
            OFS_B_DIR: next_rdata = b_dir;
            OFS_E_DATA: next_rdata = e_rd;
            OFS_E_DIR: next_rdata = e_dir;
            OFS_ASSIGN: next_rdata = asg;
            OFS_MODE: next_rdata = {mode_f, 1'b0, vis, 3'h0};
            OFS_PULL: next_rdata = pull_enable;
            OFS_DRIVE: next_rdata = reduce_drive;
            OFS_EBI: next_rdata = ebi;
            OFS_IRQ: next_rdata = irqc;
            OFS_K_DATA: next_rdata = (k_dir & k_dat) | (~k_dir & pk);
            OFS_K_DIR: next_rdata = k_dir;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_read ? next_rdata : 8'h00;
        end
    end

    // ==========================================
    // mode decode
    logic expanded, periph, wide_md, emul, bus_master, tag_md;

    assign expanded = mode_f != MD_SSC && mode_f != MD_NSC;
    assign periph = mode_f == MD_PERI;
    assign wide_md = mode_f == MD_EMW || mode_f == MD_NXW
        || mode_f == MD_STEST || periph;
    assign emul = mode_f == MD_EMN || mode_f == MD_EMW;
    assign bus_master = expanded && !periph;
    assign tag_md = mode_f == MD_NXW || mode_f == MD_EMW
        || mode_f == MD_EMN;

    // ==========================================
    // bus cycle sequencer
    mbp_state_e state, next_state;
    mbp_req_s cur;
    logic [3:0] cnt;
    logic phase, free_run, busy, accept, seen, data_end, strobe;

    assign free_run = !asg[ASG_STROBE_OFF];
    assign seen = !req.internal || vis;
    assign req_ready = state == ST_IDLE && bus_master
        && (!free_run || phase);
    assign accept = req_valid && req_ready;
    assign busy = state == ST_ADDR || state == ST_DATA;
    assign data_end = state == ST_DATA && cnt == 4'h0;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept && seen) begin
                    next_state = ST_ADDR;
                end
            end
            ST_ADDR: next_state = ST_DATA;
            ST_DATA: begin
                if (cnt == 4'h0) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cur <= '0;
        end else if (accept) begin
            cur <= req;
        end
    end

    // high phase length, stretched for slow accesses
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt <= 4'h0;
        end else if (state == ST_ADDR) begin
            cnt <= (cur.slow && ebi[EBI_STRETCH])
                ? DATA_CYC + STRETCH_CYC - 4'h1
                : DATA_CYC - 4'h1;
        end else if (state == ST_DATA && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            phase <= 1'b0;
        end else if (state == ST_IDLE) begin
            phase <= !phase;
        end else begin
            phase <= 1'b0;
        end
    end

    assign strobe = state == ST_DATA
        || (state == ST_IDLE && free_run && phase);

    always_ff @(posedge clk) begin
        if (reset) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= data_end || (accept && !seen);
            if (data_end && !cur.write) begin
                rsp_rdata <= wide_md ? {pa, pb} : {8'h00, pa};
            end else if (accept) begin
                rsp_rdata <= 16'h0000;
            end
        end
    end

    // ==========================================
    // port A, B and K pins
    logic [7:0] bus_a, bus_b, bus_a_oe, bus_b_oe;

    always_comb begin
        bus_a = cur.addr[15:8];
        bus_b = cur.addr[7:0];
        bus_a_oe = 8'h00;
        bus_b_oe = 8'h00;
        if (state == ST_ADDR) begin
            bus_a_oe = 8'hFF;
            bus_b_oe = 8'hFF;
        end else if (state == ST_DATA) begin
            bus_a = wide_md ? cur.wdata[15:8] : cur.wdata[7:0];
            bus_a_oe = cur.write ? 8'hFF : 8'h00;
            if (wide_md) begin
                bus_b = cur.wdata[7:0];
                bus_b_oe = cur.write ? 8'hFF : 8'h00;
            end else begin
                bus_b_oe = 8'hFF;
            end
        end
    end

    assign a_out = expanded ? bus_a : a_dat;
    assign b_out = expanded ? bus_b : b_dat;
    assign a_oe = periph ? 8'h00 : (bus_master ? bus_a_oe : a_dir);
    assign b_oe = periph ? 8'h00 : (bus_master ? bus_b_oe : b_dir);
    assign k_out = bus_master ? {!(busy && emul), !(busy && !emul),
        cur.page} : k_dat;
    assign k_oe = bus_master ? 8'hFF : k_dir;

    // ==========================================
    // port E pins
    logic low_byte_strobe_n, rw_level;
    logic [7:0] e_fn, e_fun_out;

    assign low_byte_strobe_n = !(busy
        && (!wide_md || cur.wide || cur.addr[0]));
    assign rw_level = !(busy && cur.write);
    assign e_fn = {3'h0, !periph && (free_run || expanded),
        bus_master && asg[ASG_LOW_BYTE_STROBE_N_EN],
        bus_master && asg[ASG_RW_EN], 2'h0};
    assign e_fun_out = {3'h0, strobe, low_byte_strobe_n, rw_level, 2'h0};
    assign e_out = (e_fn & e_fun_out) | (~e_fn & e_dat);
    assign e_oe = periph ? (e_dir & ~(E_INPUT_ONLY | E_PERI_IN))
        : ((e_fn | e_dir) & ~E_INPUT_ONLY);
    assign tester_write = periph && !pe[2];
    assign tester_byte = periph && pe[3];

    // ==========================================
    // tagging and interrupts
    logic tag_ok, irq_prev, irq_latch, irq_fall;

    assign tag_ok = tag_md && ebi[EBI_TAG] && asg[ASG_LOW_BYTE_STROBE_N_EN];

    always_ff @(posedge clk) begin
        if (reset) begin
            low_tag_hit <= 1'b0;
        end else begin
            low_tag_hit <= tag_ok && data_end && !cur.write
                && !pe[3];
        end
    end

    assign irq_fall = irq_prev && !pe[1];

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_prev <= 1'b1;
            irq_latch <= 1'b0;
        end else begin
            irq_prev <= pe[1];
            if (irq_fall) begin
                irq_latch <= 1'b1;
            end else if (irq_ack) begin
                irq_latch <= 1'b0;
            end
        end
    end

    assign maskable_irq = irqc[IRQ_EN]
        && (irqc[IRQ_EDGE] ? irq_latch : !pe[1]);
    assign nonmaskable_interrupt_request = !pe[0];

    // ==========================================
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_free_toggle: assert property (
        (state == ST_IDLE && free_run) ##1 (state == ST_IDLE && free_run)
        |-> strobe != $past(strobe))
        else $error("free strobe stalled");
    a_one_pulse: assert property (
        accept && seen |=> !strobe ##1 strobe)
        else $error("access pulse wrong");
    a_stretch_len: assert property (
        state == ST_ADDR && cur.slow && ebi[EBI_STRETCH]
        |=> strobe [*6] ##1 !strobe)
        else $error("stretch length wrong");
    a_gated_idle: assert property (
        state == ST_IDLE && !free_run |-> !strobe)
        else $error("gated strobe idle high");
    a_low_byte_strobe_n_wide: assert property (
        busy && wide_md && cur.wide |-> !low_byte_strobe_n)
        else $error("low strobe not asserted");
    a_tag_sample: assert property (
        low_tag_hit |-> $past(tag_ok && data_end && !pe[3]))
        else $error("tag without cause");
    a_rw_input: assert property (
        periph |-> !e_oe[2] && !e_oe[3] && a_oe == 8'h00)
        else $error("driven in peripheral mode");
    a_e1_read: assert property (
        reg_read && ofs == OFS_E_DATA |=> !e_oe[1]
        && reg_rdata[1] == $past(pe[1]))
        else $error("pin 1 not readable");
    a_irq_edge: assert property (
        irqc[IRQ_EN] && irqc[IRQ_EDGE] && irq_fall |=> maskable_irq)
        else $error("edge irq lost");
    a_assign_rd: assert property (
        reg_read && ofs == OFS_ASSIGN |=> reg_rdata == $past(asg))
        else $error("assign read wrong");
    a_strap_catch: assert property (
        $fell(reset) |=> mode_f == $past({pin[32], pe[6], pe[5]}))
        else $error("strap not captured");
    a_addr_low: assert property (
        state == ST_ADDR && bus_master
        |-> a_out == cur.addr[15:8] && !strobe)
        else $error("address phase wrong");
    a_page_out: assert property (
        busy && bus_master |-> k_out[5:0] == cur.page && k_oe == 8'hFF)
        else $error("page bits wrong");
    a_rsvd_zero: assert property (
        reg_read && ofs == OFS_RSVD_04 |=> reg_rdata == 8'h00)
        else $error("reserved not zero");

    c_free_access: cover property (free_run && accept ##5 data_end);
    c_slow_access: cover property (state == ST_ADDR && cur.slow
        && ebi[EBI_STRETCH]);
    c_tag_hit: cover property (low_tag_hit);
    c_edge_irq: cover property (irq_fall && irqc[IRQ_EDGE]);
endmodule : mbp_top

// ---- tb/mbp_ext_bus.sv ----
`timescale 1ns/1ns
// ==========================================
// external memory on the multiplexed bus
module mbp_ext_bus (
    input wire logic clk,
    input wire logic [7:0] a_out,
    input wire logic [7:0] a_oe,
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe,
    input wire logic strobe,
    input wire logic read,
    output logic [7:0] a_pin,
    output logic [7:0] b_pin
);
    logic [15:0] addr_q = 16'h0000;
    logic [7:0] noise = 8'h00;
    logic [7:0] a_ext;
    logic [7:0] b_ext;
    // ==========================================
    // address capture, floating pattern
    always_ff @(posedge clk) begin
        if (!strobe && a_oe == 8'hFF && b_oe == 8'hFF) begin
            addr_q <= {a_out, b_out};
        end
        noise <= noise + 8'h5B;
    end
    // ==========================================
    // read data while strobe high, else floating
    assign a_ext = (strobe && read) ? addr_q[7:0] ^ 8'hA5 : noise;
    assign b_ext = (strobe && read) ? addr_q[15:8] ^ 8'h3C : ~noise;
    assign a_pin = (a_oe & a_out) | (~a_oe & a_ext);
    assign b_pin = (b_oe & b_out) | (~b_oe & b_ext);
endmodule : mbp_ext_bus

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
// ==========================================
// bench for the multiplexed bus pin block
module tb_top;
    import mbp_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    mbp_req_s req = '0;
    logic req_valid = 1'b0;
    logic req_ready, rsp_valid, tag_hit, t_write, t_byte, irq, nmi;
    logic [15:0] rsp_rdata;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic irq_ack = 1'b0;
    logic strap_c = 1'b1;
    logic [7:0] e_drv = 8'hFF;
    logic [7:0] reg_rdata, a_out, a_oe, b_out, b_oe, e_out, e_oe, k_out, k_oe;
    logic [7:0] a_pin, b_pin, e_pin, pull_en, drive_red;
    logic [5:0] ofs_tab [15] = '{OFS_A_DIR, OFS_B_DIR, OFS_E_DIR, OFS_ASSIGN,
        OFS_PULL, OFS_EBI, OFS_DRIVE, OFS_IRQ, OFS_K_DIR, OFS_MODE, 6'h04,
        6'h05, 6'h06, 6'h07, 6'h0F};
    logic [7:0] rst_tab [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, RST_IRQ, 8'h00, 8'hE0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int fail_count = 0;
    int checks = 0;
    int seed = 32'hEC1A;
    mbp_req_s r;
    logic [7:0] d;
    logic prev;
    logic tag_en = 1'b0;
    always #5 clk = ~clk;
    assign e_pin = (e_oe & e_out) | (~e_oe & e_drv);
    mbp_ext_bus ext (.clk(clk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out),
        .b_oe(b_oe), .strobe(e_out[4]), .read(e_out[2] & e_oe[2]),
        .a_pin(a_pin), .b_pin(b_pin));
    mbp_top dut (.clk(clk), .reset(reset), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .a_in(a_pin),
        .a_out(a_out), .a_oe(a_oe), .b_in(b_pin), .b_out(b_out), .b_oe(b_oe),
        .e_in(e_pin), .e_out(e_out), .e_oe(e_oe),
        .k_in((k_oe & k_out) | ~k_oe), .k_out(k_out), .k_oe(k_oe),
        .mode_strap_c(strap_c), .irq_ack(irq_ack), .maskable_irq(irq),
        .nonmaskable_interrupt_request(nmi), .low_tag_hit(tag_hit),
        .tester_write(t_write), .tester_byte(t_byte), .pull_enable(pull_en),
        .reduce_drive(drive_red));
    // ==========================================
    // checking and expectation helpers
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic print_verdict;
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    function automatic logic [15:0] exp_lat(input mbp_req_s q);
        if (q.internal) return 16'h0001;
        return 16'(2 + DATA_CYC + (q.slow ? STRETCH_CYC : 4'h0));
    endfunction : exp_lat
    function automatic logic [15:0] exp_rd(input logic [15:0] a);
        return {a[7:0] ^ 8'hA5, a[15:8] ^ 8'h3C};
    endfunction : exp_rd
    // ==========================================
    // register bus and reset
    task automatic wr(input logic [5:0] ofs, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= {10'($random(seed)), ofs};
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] ofs, input logic [7:0] exp,
        input logic [7:0] m, input string what);
        @(posedge clk);
        reg_addr <= {10'($random(seed)), ofs};
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        chk(what, {8'h00, exp & m}, {8'h00, reg_rdata & m});
    endtask : rd
    task automatic do_reset(input logic [2:0] mode);
        @(posedge clk);
        reset <= 1'b1;
        strap_c <= mode[2];
        e_drv <= {1'b1, mode[1:0], 5'h1F};
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset
    task automatic pin_e(input int bit_no, input logic v);
        @(posedge clk);
        e_drv[bit_no] <= v;
        repeat (6) @(negedge clk);
    endtask : pin_e
    // ==========================================
    // one bus access through the access port
    task automatic access(input mbp_req_s q);
        logic [15:0] s_addr, s_data;
        logic [7:0] s_k;
        logic lo, rw, pv;
        int n, rises;
        s_addr = 16'h0000;
        s_data = 16'h0000;
        s_k = 8'h00;
        lo = 1'b0;
        rw = 1'b0;
        n = 0;
        rises = 0;
        @(posedge clk);
        req <= q;
        req_valid <= 1'b1;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk("ready timeout", 16'h0000, 16'(n / 50));
        pv = e_out[4];
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
            if (e_out[4] && !pv) rises++;
            pv = e_out[4];
            if (!e_out[4] && a_oe == 8'hFF) s_addr = {a_out, b_out};
            if (e_out[4]) begin
                s_data = {a_out, b_out};
                lo = e_out[3];
                rw = e_out[2];
                s_k = k_out;
            end
        end
        chk("latency", exp_lat(q), 16'(n));
        chk("strobe pulses", q.internal ? 16'h0 : 16'h1, 16'(rises));
        if (q.internal) return;
        chk("low tag", 16'(tag_en && !q.write && (q.wide || q.addr[0])),
            16'(tag_hit));
        chk("address phase", q.addr, s_addr);
        chk("low strobe", 16'(!(q.wide || q.addr[0])), 16'(lo));
        chk("direction pin", 16'(!q.write), 16'(rw));
        chk("page pins", {9'h000, 1'b0, q.page}, {9'h000, s_k[6:0]});
        if (!q.wide) return;
        if (q.write) chk("data phase", q.wdata, s_data);
        chk("read data", q.write ? 16'h0 : exp_rd(q.addr), rsp_rdata);
    endtask : access
    // ==========================================
    // main sequence
    initial begin
        #900000;
        fail_count++;
        print_verdict();
    end
    initial begin
        do_reset(3'h7);
        for (int i = 0; i < 15; i++) begin
            rd(ofs_tab[i], rst_tab[i], 8'hFF, "reset value");
        end
        @(negedge clk);
        prev = e_out[4];
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            chk("free strobe", 16'(!prev), 16'(e_out[4]));
            prev = e_out[4];
        end
        for (int i = 0; i < 5; i++) begin
            d = 8'($random(seed));
            wr(ofs_tab[(i < 2) ? i : i + 2], d);
            rd(ofs_tab[(i < 2) ? i : i + 2], d, 8'hFF, "rw reg");
            if (i == 2) chk("pull out", {8'h00, d}, {8'h00, pull_en});
        end
        @(negedge clk);
        chk("drive out", {8'h00, d}, {8'h00, drive_red});
        for (int i = 10; i < 15; i++) begin
            wr(ofs_tab[i], 8'hFF);
            rd(ofs_tab[i], 8'h00, 8'hFF, "reserved");
        end
        wr(OFS_E_DIR, 8'hFF);
        rd(OFS_E_DIR, 8'hFC, 8'hFF, "e direction");
        chk("e input oe", 16'h0, {14'h0, e_oe[1:0]});
        wr(OFS_E_DIR, 8'h00);
        wr(OFS_A_DIR, 8'h00);
        wr(OFS_B_DIR, 8'h00);
        wr(OFS_K_DIR, 8'h00);
        wr(OFS_ASSIGN, 8'h1C);
        wr(OFS_EBI, 8'h01);
        repeat (2) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            chk("gated idle", 16'h0, 16'(e_out[4]));
        end
        for (int i = 0; i < 20; i++) begin
            r.addr = 16'($random(seed));
            r.wdata = 16'($random(seed));
            r.page = 6'($random(seed));
            r.write = 1'($random(seed));
            r.slow = 1'($random(seed));
            r.wide = (i > 1);
            r.internal = (i > 3) && (2'($random(seed)) == 2'h0);
            if (i < 2) r.addr[0] = i[0];
            access(r);
        end
        wr(OFS_ASSIGN, 8'h0C);
        wr(OFS_EBI, 8'h10);
        tag_en = 1'b1;
        r.write = 1'b0;
        r.wide = 1'b1;
        r.slow = 1'b0;
        r.internal = 1'b0;
        access(r);
        pin_e(1, 1'b0);
        chk("irq level low", 16'h1, 16'(irq));
        rd(OFS_E_DATA, 8'h00, 8'h02, "irq pin read");
        pin_e(1, 1'b1);
        chk("irq level high", 16'h0, 16'(irq));
        rd(OFS_E_DATA, 8'h02, 8'h02, "irq pin read");
        wr(OFS_IRQ, 8'hC0);
        pin_e(1, 1'b0);
        pin_e(1, 1'b1);
        chk("irq edge held", 16'h1, 16'(irq));
        @(posedge clk);
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        repeat (2) @(negedge clk);
        chk("irq edge cleared", 16'h0, 16'(irq));
        pin_e(0, 1'b0);
        chk("nmi", 16'h1, 16'(nmi));
        do_reset(3'h6);
        rd(OFS_MODE, 8'hC0, 8'hE0, "strap mode");
        pin_e(2, 1'b0);
        chk("tester write", 16'h1, 16'(t_write));
        chk("tester byte", 16'h1, 16'(t_byte));
        chk("rw pin input", 16'h0, 16'(e_oe[2]));
        chk("no bus master", 16'h0, 16'(req_ready));
        pin_e(3, 1'b0);
        chk("tester word", 16'h0, 16'(t_byte));
        print_verdict();
    end
endmodule : tb_top
